// file: logic/rpcg_top.sv
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module rpcg_top
    import rpcg_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_sleep,
    input wire logic i_deep_sleep,
    input wire rpcg_access_t i_access,
    output logic [DATA_W-1:0] o_rdata,
    output logic [PORT_N-1:0] o_port_clk_en,
    output logic [SER_N-1:0] o_serial_clk_en,
    output logic o_access_ok,
    output logic o_bus_fault,
    output logic o_irq
);

    rpcg_gate_t run_gate;
    rpcg_gate_t slp_gate;
    rpcg_gate_t dsl_gate;
    logic auto_clock_gate_select;
    logic [EV_N-1:0] irq_stat;
    logic [EV_N-1:0] irq_mask;

    rpcg_mode_t mode;
    rpcg_gate_t live_gate;
    rpcg_gate_t next_gate;
    logic [DATA_W-1:0] next_rdata;
    logic [EV_N-1:0] ev;
    logic [EV_N-1:0] w1c;
    logic sel_ser;
    logic [SEL_W-1:0] ser_idx;
    logic sel_legal;
    logic sel_on;
    logic port_fault;
    logic ser_fault;
    logic next_ok;
    logic next_fault;
    logic [EV_N-1:0] next_irq_stat;
    logic next_irq;
    logic use_deep;
    logic use_sleep;

    // zero-padded read views of each register
    logic [DATA_W-1:0] run_port_word;
    logic [DATA_W-1:0] ser_gate_word;
    logic [DATA_W-1:0] slp_port_word;
    logic [DATA_W-1:0] dsl_port_word;
    logic [DATA_W-1:0] slp_ser_word;
    logic [DATA_W-1:0] dsl_ser_word;
    logic [DATA_W-1:0] cfg_word;
    logic [DATA_W-1:0] irq_stat_word;
    logic [DATA_W-1:0] irq_mask_word;

    logic wr_run_port;
    logic wr_ser_gate;
    logic wr_slp_port;
    logic wr_dsl_port;
    logic wr_slp_ser;
    logic wr_dsl_ser;
    logic wr_cfg;
    logic wr_irq_stat;
    logic wr_irq_mask;

    assign wr_run_port = i_wr && (i_addr == OFF_RUN_PORT);
    assign wr_ser_gate = i_wr && (i_addr == OFF_SER_GATE);
    assign wr_slp_port = i_wr && (i_addr == OFF_SLP_PORT);
    assign wr_dsl_port = i_wr && (i_addr == OFF_DSL_PORT);
    assign wr_slp_ser = i_wr && (i_addr == OFF_SLP_SER);
    assign wr_dsl_ser = i_wr && (i_addr == OFF_DSL_SER);
    assign wr_cfg = i_wr && (i_addr == OFF_RUN_CFG);
    assign wr_irq_stat = i_wr && (i_addr == OFF_IRQ_STAT);
    assign wr_irq_mask = i_wr && (i_addr == OFF_IRQ_MASK);

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            run_gate.port <= PORT_RST;
        end else if (wr_run_port) begin
            run_gate.port <= i_wdata[PORT_N-1:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            run_gate.serial <= SER_RST;
        end else if (wr_ser_gate) begin
            run_gate.serial <= i_wdata[SER_N-1:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            slp_gate.port <= PORT_RST;
        end else if (wr_slp_port) begin
            slp_gate.port <= i_wdata[PORT_N-1:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            slp_gate.serial <= SER_RST;
        end else if (wr_slp_ser) begin
            slp_gate.serial <= i_wdata[SER_N-1:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            dsl_gate.port <= PORT_RST;
        end else if (wr_dsl_port) begin
            dsl_gate.port <= i_wdata[PORT_N-1:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            dsl_gate.serial <= SER_RST;
        end else if (wr_dsl_ser) begin
            dsl_gate.serial <= i_wdata[SER_N-1:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            auto_clock_gate_select <= 1'b0;
        end else if (wr_cfg) begin
            auto_clock_gate_select <= i_wdata[AUTO_BIT];
        end
    end

    // copies need auto select
    // deep sleep outranks sleep when both are raised
    assign use_deep = auto_clock_gate_select && i_deep_sleep;
    assign use_sleep = auto_clock_gate_select && i_sleep && !i_deep_sleep;

    always_comb begin
        mode = RPCG_RUN;
        if (use_deep) begin
            mode = RPCG_DEEP;
        end else if (use_sleep) begin
            mode = RPCG_SLEEP;
        end
    end

    always_comb begin
        unique case (mode)
            RPCG_RUN: next_gate = run_gate;
            RPCG_SLEEP: next_gate = slp_gate;
            RPCG_DEEP: next_gate = dsl_gate;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_port_clk_en <= PORT_RST;
        end else begin
            o_port_clk_en <= next_gate.port;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_serial_clk_en <= SER_RST;
        end else begin
            o_serial_clk_en <= next_gate.serial;
        end
    end

    // decode uses the enables the peripherals really see
    // write field is informational and not decoded
    assign live_gate = {o_serial_clk_en, o_port_clk_en};
    assign sel_ser = (i_access.sel >= SEL_SER_BASE);
    assign ser_idx = i_access.sel - SEL_SER_BASE;
    assign sel_legal = (i_access.sel <= SEL_LAST);

    always_comb begin
        sel_on = 1'b0;
        if (!sel_legal) begin
            sel_on = 1'b0;
        end else if (sel_ser) begin
            sel_on = live_gate.serial[ser_idx[1:0]];
        end else begin
            sel_on = live_gate.port[i_access.sel[2:0]];
        end
    end

    // illegal selectors are booked as serial faults
    assign port_fault = i_access.valid && !sel_on && !sel_ser;
    assign ser_fault = i_access.valid && !sel_on && sel_ser;
    assign next_fault = i_access.valid && !sel_on;
    assign next_ok = i_access.valid && sel_on;

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_bus_fault <= 1'b0;
        end else begin
            o_bus_fault <= next_fault;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_access_ok <= 1'b0;
        end else begin
            o_access_ok <= next_ok;
        end
    end

    always_comb begin
        ev = EV_RST;
        ev[EV_PORT_FAULT] = port_fault;
        ev[EV_SER_FAULT] = ser_fault;
    end

    assign w1c = wr_irq_stat ? i_wdata[EV_N-1:0] : EV_RST;

    // new event beats a same-cycle clear
    assign next_irq_stat = (irq_stat & ~w1c) | ev;
    assign next_irq = |(next_irq_stat & irq_mask);

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            irq_stat <= EV_RST;
        end else begin
            irq_stat <= next_irq_stat;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            irq_mask <= EV_RST;
        end else if (wr_irq_mask) begin
            irq_mask <= i_wdata[EV_N-1:0];
        end
    end

    // level follows the status this edge leaves behind, kept registered
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= next_irq;
        end
    end

    assign run_port_word = {{(DATA_W - PORT_N){1'b0}}, run_gate.port};
    assign ser_gate_word = {{(DATA_W - SER_N){1'b0}}, run_gate.serial};
    assign slp_port_word = {{(DATA_W - PORT_N){1'b0}}, slp_gate.port};
    assign dsl_port_word = {{(DATA_W - PORT_N){1'b0}}, dsl_gate.port};
    assign slp_ser_word = {{(DATA_W - SER_N){1'b0}}, slp_gate.serial};
    assign dsl_ser_word = {{(DATA_W - SER_N){1'b0}}, dsl_gate.serial};
    assign irq_stat_word = {{(DATA_W - EV_N){1'b0}}, irq_stat};
    assign irq_mask_word = {{(DATA_W - EV_N){1'b0}}, irq_mask};

    // auto select is the only live bit of the config word
    always_comb begin
        cfg_word = ZERO_WORD;
        cfg_word[AUTO_BIT] = auto_clock_gate_select;
    end

    always_comb begin
        next_rdata = ZERO_WORD;
        unique case (i_addr)
            OFF_RUN_PORT: next_rdata = run_port_word;
            OFF_SER_GATE: next_rdata = ser_gate_word;
            OFF_SLP_PORT: next_rdata = slp_port_word;
            OFF_DSL_PORT: next_rdata = dsl_port_word;
            OFF_SLP_SER: next_rdata = slp_ser_word;
            OFF_DSL_SER: next_rdata = dsl_ser_word;
            OFF_RUN_CFG: next_rdata = cfg_word;
            OFF_IRQ_STAT: next_rdata = irq_stat_word;
            OFF_IRQ_MASK: next_rdata = irq_mask_word;
            default: next_rdata = ZERO_WORD;
        endcase
    end

    // data only in the cycle after the read strobe
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_rdata <= ZERO_WORD;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= ZERO_WORD;
        end
    end

endmodule : rpcg_top
`default_nettype wire

// file: logic/rpcg_pkg.sv
// Contract
// - A set enable bit delivers the peripheral's clock and a clear bit withholds it.
// - An access to a peripheral whose clock is gated off is answered with a bus fault.
// - After reset every gating enable bit is zero, so nothing is clocked.
// - The run-mode register governs the clocks in normal run; the sleep and deep-sleep copies govern those states.
// - The sleep copies take effect only while the auto clock gating select bit is set.
// - Bits 7 to 0 of the run port gate register each gate one port, bit 0 port A to bit 7 port H, read/write.
// - Bits 31:8 of the run port gate register are read-only and read as zero.
// - Bits 2, 1 and 0 of the serial unit gate register gate serial units 2, 1 and 0, read/write, reset zero.
// - The run port gate register sits at offset 0x108 and resets to all zeros.
package rpcg_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int PORT_N = 8;
    localparam int SER_N = 3;
    localparam int SEL_W = 4;

    localparam logic [ADDR_W-1:0] OFF_RUN_CFG = 12'h060;
    localparam logic [ADDR_W-1:0] OFF_SER_GATE = 12'h104;
    localparam logic [ADDR_W-1:0] OFF_RUN_PORT = 12'h108;
    localparam logic [ADDR_W-1:0] OFF_SLP_PORT = 12'h118;
    localparam logic [ADDR_W-1:0] OFF_DSL_PORT = 12'h128;
    localparam logic [ADDR_W-1:0] OFF_SLP_SER = 12'h114;
    localparam logic [ADDR_W-1:0] OFF_DSL_SER = 12'h124;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 12'h200;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h204;

    localparam int AUTO_BIT = 27;
    localparam int EV_PORT_FAULT = 0;
    localparam int EV_SER_FAULT = 1;
    localparam int EV_N = 2;

    // selector codes 0..7 are ports a..h, 8..10 serial units 0..2
    localparam logic [SEL_W-1:0] SEL_SER_BASE = 4'h8;
    localparam logic [SEL_W-1:0] SEL_LAST = 4'ha;

    localparam logic [PORT_N-1:0] PORT_RST = 8'h00;
    localparam logic [SER_N-1:0] SER_RST = 3'h0;
    localparam logic [EV_N-1:0] EV_RST = 2'h0;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

    typedef struct packed {
        logic [SER_N-1:0] serial;
        logic [PORT_N-1:0] port;
    } rpcg_gate_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [SEL_W-1:0] sel;
    } rpcg_access_t;

    typedef enum logic [1:0] {
        RPCG_RUN,
        RPCG_SLEEP,
        RPCG_DEEP
    } rpcg_mode_t;
endpackage : rpcg_pkg

// file: dv/rpcg_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rpcg_top_asserts
    import rpcg_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_sleep,
    input wire logic i_deep_sleep,
    input wire rpcg_access_t i_access,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic [PORT_N-1:0] o_port_clk_en,
    input wire logic [SER_N-1:0] o_serial_clk_en,
    input wire logic o_access_ok,
    input wire logic o_bus_fault,
    input wire logic o_irq
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    sequence port_req;
        i_access.valid && i_access.sel < SEL_SER_BASE;
    endsequence
    sequence ser_req;
        i_access.valid && i_access.sel >= SEL_SER_BASE && i_access.sel <= SEL_LAST;
    endsequence
    sequence faulted;
        o_bus_fault && !o_access_ok;
    endsequence
    chk_port_gated_fault: assert property (port_req ##0 !o_port_clk_en[i_access.sel[2:0]]
        |=> faulted) else $error("gated port access not faulted");
    chk_port_clocked_ok: assert property (port_req ##0 o_port_clk_en[i_access.sel[2:0]]
        |=> o_access_ok && !o_bus_fault) else $error("clocked port access not accepted");
    chk_serial_gated: assert property (ser_req ##0 !o_serial_clk_en[i_access.sel - SEL_SER_BASE]
        |=> faulted) else $error("gated serial access not faulted");
    chk_illegal_sel: assert property (i_access.valid && i_access.sel > SEL_LAST |=> faulted)
        else $error("illegal selector not faulted");
    chk_no_spurious_answer: assert property (!i_access.valid |=> !o_access_ok && !o_bus_fault)
        else $error("answer without access");
    chk_rdata_idle_zero: assert property (!i_rd |=> o_rdata == ZERO_WORD)
        else $error("read data outside answer cycle");
    chk_run_write_applies: assert property (i_wr && i_addr == OFF_RUN_PORT ##1 !i_sleep
        && !i_deep_sleep |=> o_port_clk_en == $past(i_wdata[PORT_N-1:0], 2))
        else $error("run gate write not applied");
    chk_reset_all_off: assert property (disable iff (1'b0) !i_nrst |=> o_port_clk_en == PORT_RST
        && o_serial_clk_en == SER_RST && !o_irq) else $error("enables not cleared by reset");
endmodule : rpcg_top_asserts
bind rpcg_top rpcg_top_asserts rpcg_top_asserts_i (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_sleep(i_sleep),
    .i_deep_sleep(i_deep_sleep), .i_access(i_access), .o_rdata(o_rdata),
    .o_port_clk_en(o_port_clk_en), .o_serial_clk_en(o_serial_clk_en),
    .o_access_ok(o_access_ok), .o_bus_fault(o_bus_fault), .o_irq(o_irq));
`default_nettype wire

// file: dv/rpcg_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rpcg_top_bench
    import rpcg_pkg::*;
;
    logic i_mclk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_sleep = 0, i_deep_sleep = 0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_wdata = '0;
    rpcg_access_t i_access = '0;
    logic [DATA_W-1:0] o_rdata;
    logic [PORT_N-1:0] o_port_clk_en;
    logic [SER_N-1:0] o_serial_clk_en;
    logic o_access_ok, o_bus_fault, o_irq;
    int fails = 0, cmp_count = 0;
    rpcg_top rpcg_top_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_sleep(i_sleep), .i_deep_sleep(i_deep_sleep),
        .i_access(i_access), .o_rdata(o_rdata), .o_port_clk_en(o_port_clk_en),
        .o_serial_clk_en(o_serial_clk_en), .o_access_ok(o_access_ok),
        .o_bus_fault(o_bus_fault), .o_irq(o_irq));
    always #50 i_mclk = ~i_mclk;
    task chk(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr
    task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk("rdata", o_rdata, exp);
    endtask : rd
    task acc(input logic [SEL_W-1:0] s, input logic ok);
        @(posedge i_mclk);
        i_access <= {1'b1, 1'b0, s};
        @(posedge i_mclk);
        i_access <= '0;
        #1 chk("access_ok", o_access_ok, ok);
        chk("bus_fault", o_bus_fault, !ok);
    endtask : acc
    task pwr(input logic s, input logic d);
        @(posedge i_mclk);
        i_sleep <= s;
        i_deep_sleep <= d;
        repeat (2) @(posedge i_mclk);
        #1;
    endtask : pwr
    task t_reset;
        rd(OFF_RUN_PORT, ZERO_WORD);
        rd(OFF_SER_GATE, ZERO_WORD);
        chk("port_en", o_port_clk_en, PORT_RST);
        acc(4'h0, 1'b0);
        $display("t_reset done");
    endtask : t_reset
    task t_ports;
        for (int n = 0; n < PORT_N; n++) begin
            // reserved ones must not stick
            // port enabled before access
            wr(OFF_RUN_PORT, 32'hffff_ff00 | (32'h1 << n));
            rd(OFF_RUN_PORT, 32'h1 << n);
            chk("port_en", o_port_clk_en, 8'h1 << n);
            acc(4'(n), 1'b1);
            acc(4'((n + 1) % PORT_N), 1'b0);
        end
        $display("t_ports done");
    endtask : t_ports
    task t_serial;
        wr(OFF_SER_GATE, 32'hffff_fff5);
        rd(OFF_SER_GATE, 32'h5);
        chk("serial_en", o_serial_clk_en, 3'h5);
        acc(4'h8, 1'b1);
        acc(4'h9, 1'b0);
        acc(4'ha, 1'b1);
        acc(4'hf, 1'b0);
        $display("t_serial done");
    endtask : t_serial
    task t_irq;
        wr(OFF_IRQ_MASK, 32'h3);
        rd(OFF_IRQ_STAT, 32'h3);
        chk("irq", o_irq, 1'b1);
        wr(OFF_IRQ_STAT, 32'h3);
        rd(OFF_IRQ_STAT, ZERO_WORD);
        chk("irq", o_irq, 1'b0);
        acc(4'h9, 1'b0);
        chk("irq", o_irq, 1'b1);
        rd(OFF_IRQ_STAT, 32'h2);
        // same-cycle event and clear: the event stays
        fork
            wr(OFF_IRQ_STAT, 32'h2);
            acc(4'h9, 1'b0);
        join
        rd(OFF_IRQ_STAT, 32'h2);
        chk("irq", o_irq, 1'b1);
        wr(OFF_IRQ_MASK, ZERO_WORD);
        rd(12'h300, ZERO_WORD);
        chk("irq", o_irq, 1'b0);
        $display("t_irq done");
    endtask : t_irq
    task t_modes;
        wr(OFF_RUN_PORT, 32'hf0);
        wr(OFF_SLP_PORT, 32'h0f);
        wr(OFF_DSL_PORT, 32'h3c);
        wr(OFF_SLP_SER, 32'h2);
        wr(OFF_DSL_SER, 32'h4);
        rd(OFF_SLP_SER, 32'h2);
        rd(OFF_DSL_SER, 32'h4);
        pwr(1'b1, 1'b0);
        chk("port_en", o_port_clk_en, 8'hf0);
        chk("serial_en", o_serial_clk_en, 3'h5);
        wr(OFF_RUN_CFG, 32'h1 << AUTO_BIT);
        @(posedge i_mclk);
        #1 chk("port_en", o_port_clk_en, 8'h0f);
        chk("serial_en", o_serial_clk_en, 3'h2);
        rd(OFF_RUN_CFG, 32'h1 << AUTO_BIT);
        acc(4'h0, 1'b1);
        acc(4'h9, 1'b1);
        pwr(1'b1, 1'b1);
        chk("port_en", o_port_clk_en, 8'h3c);
        chk("serial_en", o_serial_clk_en, 3'h4);
        pwr(1'b0, 1'b0);
        chk("port_en", o_port_clk_en, 8'hf0);
        chk("serial_en", o_serial_clk_en, 3'h5);
        @(posedge i_mclk);
        i_nrst <= 1'b0;
        @(posedge i_mclk);
        i_nrst <= 1'b1;
        rd(OFF_RUN_PORT, ZERO_WORD);
        chk("port_en", o_port_clk_en, PORT_RST);
        chk("serial_en", o_serial_clk_en, SER_RST);
        rd(OFF_RUN_CFG, ZERO_WORD);
        $display("t_modes done");
    endtask : t_modes
    task results;
        $display("checks %0d fails %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    initial begin
        repeat (5) @(posedge i_mclk);
        i_nrst <= 1'b1;
        t_reset;
        t_ports;
        t_serial;
        t_irq;
        t_modes;
        results();
    end
    initial begin
        repeat (3000) @(posedge i_mclk);
        fails++;
        results();
    end
endmodule : rpcg_top_bench
`default_nettype wire
